// ==== src/tmc_params.svh ====
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH

// Register byte offsets, one 32-bit word each
`define TMC_OFS_COUNT_LOW    6'h00
`define TMC_OFS_COUNT_HIGH   6'h04
`define TMC_OFS_CONTROL      6'h08
`define TMC_OFS_IRQ_FLAGS    6'h0c
`define TMC_OFS_IRQ_ENABLES  6'h10
`define TMC_OFS_OSC_CONTROL  6'h14
`define TMC_OFS_CMP_LOW      6'h18
`define TMC_OFS_CMP_HIGH     6'h1c
`define TMC_OFS_CMP_MODE     6'h20

// Timer control field positions
`define TMC_CTL_WIDE         7
`define TMC_CTL_STATUS       6
`define TMC_CTL_PS_HI        5
`define TMC_CTL_PS_LO        4
`define TMC_CTL_OSC_EN       3
`define TMC_CTL_SYNC_DIS     2
`define TMC_CTL_CLK_SEL      1
`define TMC_CTL_ON           0
`define TMC_CTL_WR_MASK      8'hbf

// Oscillator control field positions
`define TMC_OSC_IDLE_EN      7
`define TMC_OSC_MON_EN       6
`define TMC_OSC_SCS_HI       1
`define TMC_OSC_SCS_LO       0
`define TMC_SCS_SECONDARY    2'h1

// Interrupt bit positions, reset values, codes
`define TMC_IRQ_BIT          0
`define TMC_CMP_MODE_TRIG    4'hb
`define TMC_COUNT_MAX        16'hffff
`define TMC_RST_BYTE         8'h00
`define TMC_INSTR_DIV        4

`endif

// ==== src/tmc_pkg.sv ====
package tmc_pkg;

  // Power modes, Gray along run, secondary run, secondary idle
  typedef enum logic [1:0] {
    TMC_PM_RUN      = 2'h0,
    TMC_PM_SEC_RUN  = 2'h1,
    TMC_PM_SEC_IDLE = 2'h3,
    TMC_PM_SLEEP    = 2'h2
  } tmc_pmode_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } tmc_avs_req_t;

  // Whole state of the timer block
  typedef struct packed {
    logic        waitreq;
    logic [31:0] rdata;
    logic [15:0] cnt;
    logic [7:0]  hbuf;
    logic [7:0]  ctrl;
    logic        flag;
    logic        ien;
    logic        irq;
    logic [7:0]  oscctl;
    logic [15:0] cmp;
    logic [3:0]  cmode;
    logic [2:0]  presc;
    logic [3:0]  icyc;
    logic [2:0]  sync;
    logic        lvl;
    logic        need_fall;
    tmc_pmode_t  pmode;
    logic        osc_stat;
  } tmc_state_t;

endpackage

// ==== src/tmc_timer.sv ====
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "tmc_params.svh"
// What this block does
// - Select code 01 enters secondary run mode
// - Sleep with idle bit clear enters secondary idle
// - Status bit reads one on oscillator clock
// - Monitor failure drops status, polled by software
// - Count wraps from FFFFh to 0000h
// - Wrap sets sticky overflow flag until cleared
// - Interrupt passes only while enable bit set
// - Compare mode 1011 trigger resets count
// - Trigger reset ignored in asynchronous counter mode
// - Compare pair acts as period register
// - Count write beats simultaneous trigger
// - Trigger reset never sets overflow flag
// - Async update waits for falling input edge
// - Internal instruction clock or external rising edge
// - Low read latches high; low write loads
// - Prescale codes divide by 1,2,4,8
// - Sync-disable bit chooses async external counting
module tmc_timer #(
  parameter int unsigned INSTR_DIV = `TMC_INSTR_DIV
) (
  // Clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_n_i,
  // Avalon-MM slave
  input  wire tmc_pkg::tmc_avs_req_t avs_req_i,
  output logic [31:0]                avs_readdata_o,
  output logic                       avs_waitrequest_o,
  // Timer clock pins
  input  wire logic                  ext_clk_i,
  input  wire logic                  osc_clk_i,
  // Core power control
  input  wire logic                  sleep_i,
  input  wire logic                  wake_i,
  input  wire logic                  osc_fail_i,
  // Status and interrupt
  output logic                       overflow_irq_o,
  output logic [1:0]                 power_mode_o,
  output logic                       osc_clock_status_o
);

  // Instruction divider must fit the 4-bit phase counter
  if (INSTR_DIV < 1 || INSTR_DIV > 16) begin : g_chk
    $error("INSTR_DIV must be 1 to 16");
  end

  tmc_pkg::tmc_state_t st;
  tmc_pkg::tmc_state_t next_st;

  // Decode helpers shared by logic and checks
  logic       acc;
  logic       do_wr;
  logic       first;
  logic       wr_low;
  logic       wr_high;
  logic       wr_cnt;
  logic       wide;
  logic       async_m;
  logic       rise;
  logic       fall;
  logic       src_edge;
  logic       step;
  logic       inc;
  logic       trig_hit;
  logic       trig;
  logic [2:0] div_m1;
  logic [7:0] wd;

  assign acc     = avs_req_i.read | avs_req_i.write;
  assign first   = acc & st.waitreq;
  assign do_wr   = avs_req_i.write & ~st.waitreq & avs_req_i.byteenable[0];
  assign wd      = avs_req_i.writedata[7:0];
  assign wr_low  = do_wr && avs_req_i.address == `TMC_OFS_COUNT_LOW;
  assign wr_high = do_wr && avs_req_i.address == `TMC_OFS_COUNT_HIGH;
  assign wide    = st.ctrl[`TMC_CTL_WIDE];
  // A wide-mode high write only fills the buffer
  assign wr_cnt  = wr_low | (wr_high & ~wide);
  // async only with external clock selected
  assign async_m = st.ctrl[`TMC_CTL_CLK_SEL] & st.ctrl[`TMC_CTL_SYNC_DIS];

  // Filtered pin level edges; sync[0] feeds only sync[1]
  assign rise = ~st.lvl & (st.sync[1] == st.sync[2]) & st.sync[2];
  assign fall = st.lvl & (st.sync[1] == st.sync[2]) & ~st.sync[2];

  // instruction cycle tick or external rising edge
  assign src_edge = st.ctrl[`TMC_CTL_CLK_SEL] ? rise : (st.icyc == 4'(INSTR_DIV - 1));
  // async counting blocked until a falling edge
  assign step = st.ctrl[`TMC_CTL_ON] & src_edge & ~(async_m & st.need_fall);

  assign div_m1 = 3'((4'h1 << st.ctrl[`TMC_CTL_PS_HI:`TMC_CTL_PS_LO]) - 4'h1);
  assign inc    = step && st.presc == div_m1;

  // compare pair sets the period by matching the count
  assign trig_hit = st.cmode == `TMC_CMP_MODE_TRIG && st.cnt == st.cmp;
  // trigger not honoured in asynchronous mode
  assign trig     = trig_hit & ~async_m;

  always_comb begin
    next_st = st;

    // Bus handshake: one wait cycle, then accept
    next_st.waitreq = ~first;

    // Pin synchroniser and agreement filter
    next_st.sync = {st.sync[1:0], st.ctrl[`TMC_CTL_OSC_EN] ? osc_clk_i : ext_clk_i};
    if (st.sync[1] == st.sync[2]) begin
      next_st.lvl = st.sync[2];
    end
    if (fall) begin
      next_st.need_fall = 1'b0;
    end

    // Instruction phase counter
    next_st.icyc = (st.icyc == 4'(INSTR_DIV - 1)) ? 4'h0 : st.icyc + 4'h1;

    // Prescaler and counter
    if (step) begin
      next_st.presc = inc ? 3'h0 : st.presc + 3'h1;
    end
    if (inc) begin
      next_st.cnt = st.cnt + 16'h0001;
    end

    // Read side effects in the wait cycle so data and buffer agree
    if (first && avs_req_i.read) begin
      case (avs_req_i.address)
        `TMC_OFS_COUNT_LOW: begin
          next_st.rdata = {24'h0, st.cnt[7:0]};
          // low read latches live high byte
          if (wide) begin
            next_st.hbuf = st.cnt[15:8];
          end
        end
        `TMC_OFS_COUNT_HIGH:  next_st.rdata = {24'h0, wide ? st.hbuf : st.cnt[15:8]};
        // status bit shows the live clock source
        `TMC_OFS_CONTROL:     next_st.rdata = {24'h0, st.ctrl[7], st.osc_stat, st.ctrl[5:0]};
        `TMC_OFS_IRQ_FLAGS:   next_st.rdata = {31'h0, st.flag};
        `TMC_OFS_IRQ_ENABLES: next_st.rdata = {31'h0, st.ien};
        `TMC_OFS_OSC_CONTROL: next_st.rdata = {24'h0, st.oscctl};
        `TMC_OFS_CMP_LOW:     next_st.rdata = {24'h0, st.cmp[7:0]};
        `TMC_OFS_CMP_HIGH:    next_st.rdata = {24'h0, st.cmp[15:8]};
        `TMC_OFS_CMP_MODE:    next_st.rdata = {28'h0, st.cmode};
        default:              next_st.rdata = 32'h0;
      endcase
    end else if (first) begin
      next_st.rdata = 32'h0;
    end

    if (trig) begin
      next_st.cnt = 16'h0000;
    end

    // Register writes at the accepting edge
    if (do_wr) begin
      case (avs_req_i.address)
        `TMC_OFS_COUNT_LOW: begin
          next_st.cnt   = wide ? {st.hbuf, wd} : {next_st.cnt[15:8], wd};
          next_st.presc = 3'h0;
        end
        `TMC_OFS_COUNT_HIGH: begin
          if (wide) begin
            next_st.hbuf = wd;
          end else begin
            next_st.cnt = {wd, next_st.cnt[7:0]};
          end
        end
        `TMC_OFS_CONTROL:     next_st.ctrl   = wd & `TMC_CTL_WR_MASK;
        `TMC_OFS_IRQ_FLAGS:   next_st.flag   = wd[`TMC_IRQ_BIT];
        `TMC_OFS_IRQ_ENABLES: next_st.ien    = wd[`TMC_IRQ_BIT];
        `TMC_OFS_OSC_CONTROL: next_st.oscctl = wd;
        `TMC_OFS_CMP_LOW:     next_st.cmp    = {st.cmp[15:8], wd};
        `TMC_OFS_CMP_HIGH:    next_st.cmp    = {wd, st.cmp[7:0]};
        `TMC_OFS_CMP_MODE:    next_st.cmode  = wd[3:0];
        default:              next_st.cmode  = st.cmode;
      endcase
    end

    // count update in async mode rearms the falling-edge wait
    if (wr_cnt && async_m) begin
      next_st.need_fall = 1'b1;
    end

    // wrap sets flag, set wins over a clearing write
    // trigger path never reaches the flag
    if (inc && st.cnt == `TMC_COUNT_MAX) begin
      next_st.flag = 1'b1;
    end

    next_st.irq = next_st.flag & next_st.ien;

    // Power mode sequencing
    case (st.pmode)
      tmc_pkg::TMC_PM_RUN: begin
        // select code 01 moves to the timer oscillator
        if (st.oscctl[`TMC_OSC_SCS_HI:`TMC_OSC_SCS_LO] == `TMC_SCS_SECONDARY) begin
          next_st.pmode = tmc_pkg::TMC_PM_SEC_RUN;
        end
      end
      tmc_pkg::TMC_PM_SEC_RUN: begin
        if (st.oscctl[`TMC_OSC_SCS_HI:`TMC_OSC_SCS_LO] != `TMC_SCS_SECONDARY) begin
          next_st.pmode = tmc_pkg::TMC_PM_RUN;
        end else if (sleep_i) begin
          // idle bit clear gives secondary idle
          next_st.pmode = st.oscctl[`TMC_OSC_IDLE_EN] ? tmc_pkg::TMC_PM_SLEEP : tmc_pkg::TMC_PM_SEC_IDLE;
        end
      end
      tmc_pkg::TMC_PM_SEC_IDLE: begin
        if (wake_i) begin
          next_st.pmode = tmc_pkg::TMC_PM_SEC_RUN;
        end
      end
      tmc_pkg::TMC_PM_SLEEP: begin
        if (wake_i) begin
          next_st.pmode = tmc_pkg::TMC_PM_SEC_RUN;
        end
      end
      default: next_st.pmode = tmc_pkg::TMC_PM_RUN;
    endcase

    // monitor falls back on failure; select cleared so it sticks
    if (st.oscctl[`TMC_OSC_MON_EN] && osc_fail_i && st.pmode != tmc_pkg::TMC_PM_RUN) begin
      next_st.pmode = tmc_pkg::TMC_PM_RUN;
      next_st.oscctl[`TMC_OSC_SCS_HI:`TMC_OSC_SCS_LO] = 2'h0;
    end

    // status follows the mode actually taken
    next_st.osc_stat = next_st.pmode != tmc_pkg::TMC_PM_RUN;
  end

  // State register; reset takes constants only
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st         <= '0;
      st.waitreq <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign avs_readdata_o     = st.rdata;
  assign avs_waitrequest_o  = st.waitreq;
  assign overflow_irq_o     = st.irq;
  assign power_mode_o       = st.pmode;
  assign osc_clock_status_o = st.osc_stat;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  // Counting steps by exactly one
  AST_COUNT_STEP: assert property (
    inc && !wr_cnt && !trig |=> st.cnt == 16'($past(st.cnt) + 16'h0001))
    else $error("count did not step by one");

  // Wrap to zero sets flag
  AST_WRAP_FLAG: assert property (
    inc && st.cnt == 16'hffff && !wr_cnt |=> st.flag && st.cnt == 16'h0000)
    else $error("wrap did not set flag");

  // Interrupt held low while flag set and enable clear
  AST_IRQ_GATE: assert property (
    st.flag && !st.ien && !do_wr |=> !overflow_irq_o)
    else $error("interrupt passed while disabled");

  // Trigger clears count, leaves control
  AST_TRIG_CLEAR: assert property (
    trig && !do_wr |=> st.cnt == 16'h0000 && st.ctrl == $past(st.ctrl))
    else $error("trigger did not clear count only");

  // Async mode ignores trigger
  AST_ASYNC_TRIG: assert property (
    trig_hit && async_m && !inc && !wr_cnt |=> st.cnt == $past(st.cnt))
    else $error("trigger acted in async mode");

  // Trigger alone leaves flag clear
  AST_TRIG_NOFLAG: assert property (
    trig && !inc && !st.flag && !do_wr |=> !st.flag)
    else $error("trigger set overflow flag");

  // Write beats trigger
  AST_WRITE_WINS: assert property (
    trig && wr_low && !wide |=> st.cnt[7:0] == $past(avs_req_i.writedata[7:0]))
    else $error("trigger beat count write");

  // Async write blocks counting until a fall
  AST_FALL_WAIT: assert property (
    wr_cnt && async_m |=> st.need_fall ##0 !inc)
    else $error("async update did not wait for fall");

  // Low read latches high byte in wide mode
  AST_WIDE_LATCH: assert property (
    first && avs_req_i.read && avs_req_i.address == `TMC_OFS_COUNT_LOW && wide |=> st.hbuf == $past(st.cnt[15:8]))
    else $error("high byte not latched");

  // Select code enters secondary run
  AST_SEC_RUN: assert property (
    st.pmode == tmc_pkg::TMC_PM_RUN && st.oscctl[1:0] == 2'h1 |=> st.pmode == tmc_pkg::TMC_PM_SEC_RUN)
    else $error("secondary run not entered");

  // Sleep with idle bit clear gives secondary idle
  AST_SEC_IDLE: assert property (
    st.pmode == tmc_pkg::TMC_PM_SEC_RUN && st.oscctl[1:0] == 2'h1 && sleep_i && !st.oscctl[7]
      && !(st.oscctl[6] && osc_fail_i) |=> st.pmode == tmc_pkg::TMC_PM_SEC_IDLE)
    else $error("secondary idle not entered");

  // Status flag matches clock source
  AST_STATUS: assert property (
    osc_clock_status_o == (st.pmode != tmc_pkg::TMC_PM_RUN))
    else $error("status does not match source");

  // Monitor failure clears status next cycle
  AST_FAIL_DROP: assert property (
    st.oscctl[6] && osc_fail_i && st.pmode != tmc_pkg::TMC_PM_RUN |=> !osc_clock_status_o [*2])
    else $error("status kept after failure");

  // Flag holds until software clears it
  AST_FLAG_HOLD: assert property (
    st.flag && !(do_wr && avs_req_i.address == `TMC_OFS_IRQ_FLAGS) |=> st.flag)
    else $error("overflow flag dropped on its own");

  // Low write restarts the prescaler
  AST_PRESC_CLEAR: assert property (
    wr_low |=> st.presc == 3'h0)
    else $error("prescaler not cleared by low write");

  // High write leaves the prescaler alone
  AST_PRESC_KEEP: assert property (
    wr_high && !step |=> st.presc == $past(st.presc))
    else $error("prescaler disturbed by high write");

endmodule

// ==== testbench/tmc_xtal_model.sv ====
`timescale 1ns/1ps
module tmc_xtal_model #(
  parameter int EXT_HALF = 6,
  parameter int OSC_HALF = 10
) (
  // System clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // Count pins
  output logic      ext_clk_o,
  output logic      osc_clk_o,
  // Rising edges sent so far
  output int        ext_edges_o,
  output int        osc_edges_o
);
  int   cnt [2];
  int   n   [2];
  logic lvl [2];

  assign ext_clk_o   = lvl[0];
  assign osc_clk_o   = lvl[1];
  assign ext_edges_o = n[0];
  assign osc_edges_o = n[1];

  // always running
  // Crystal and pin never pause, so a count window never sees a frozen source
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    for (int i = 0; i < 2; i++) begin
      if (!rst_n_i) begin
        cnt[i] <= 0;
        n[i]   <= 0;
        lvl[i] <= 1'b0;
      end else if (cnt[i] == ((i == 0) ? EXT_HALF : OSC_HALF) - 1) begin
        cnt[i] <= 0;
        lvl[i] <= !lvl[i];
        if (!lvl[i]) begin
          n[i] <= n[i] + 1;
        end
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`include "tmc_params.svh"
module tb;
  typedef struct packed {
    logic [31:0] e;
    logic [31:0] m;
  } tmc_note_t;

  logic                  clk_sys_i    = 1'b0;
  logic                  rst_n_i      = 1'b0;
  tmc_pkg::tmc_avs_req_t req          = '0;
  logic                  sleep        = 1'b0;
  logic                  wake         = 1'b0;
  logic                  fail         = 1'b0;
  wire logic             ext_clk;
  wire logic             osc_clk;
  int                    ext_n;
  int                    osc_n;
  logic [31:0]           rdata;
  logic                  waitreq;
  logic                  irq;
  logic                  status;
  logic [1:0]            pmode;
  tmc_note_t             notes [$];
  tmc_note_t             nt;
  int                    num_errors   = 0;
  int                    total_checks = 0;
  int                    seed         = 77;
  int                    v;
  int                    e;
  int                    n_wait;
  logic [31:0]           d;
  logic [31:0]           r;

  // Short internal count so windows stay small
  tmc_timer #(.INSTR_DIV(2)) tmc_timer_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_req_i(req), .avs_readdata_o(rdata),
    .avs_waitrequest_o(waitreq), .ext_clk_i(ext_clk), .osc_clk_i(osc_clk), .sleep_i(sleep),
    .wake_i(wake), .osc_fail_i(fail), .overflow_irq_o(irq), .power_mode_o(pmode),
    .osc_clock_status_o(status));

  tmc_xtal_model tmc_xtal_model_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ext_clk_o(ext_clk), .osc_clk_o(osc_clk),
    .ext_edges_o(ext_n), .osc_edges_o(osc_n));

  // 200 MHz system clock
  always #2.5 clk_sys_i = ~clk_sys_i;

  task automatic final_report();
    $display("checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Oldest note is matched when a read is answered
  always @(posedge clk_sys_i) begin
    if (req.read && waitreq === 1'b0) begin
      nt = notes.pop_front();
      chk(rdata & nt.m, nt.e & nt.m);
    end
  end

  // Bounded wait for the slave to drop waitrequest
  task automatic wait_ack();
    int i;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_sys_i);
      if (waitreq === 1'b0) break;
    end
    if (i == 16) begin
      num_errors++;
      $display("wrong value at %0t: bus answer missing", $time);
      final_report();
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] w);
    @(posedge clk_sys_i);
    req <= '{1'b0, 1'b1, a, 4'hf, {24'h0, w}};
    wait_ack();
    req.write <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] x, input logic [31:0] m);
    notes.push_back('{x, m});
    @(posedge clk_sys_i);
    req <= '{1'b1, 1'b0, a, 4'hf, 32'h0};
    wait_ack();
    d = rdata;
    req.read <= 1'b0;
  endtask

  // Clean count from zero over a fixed window, edges from the model
  task automatic run_cnt(input logic [7:0] c);
    int x0;
    int o0;
    wr(`TMC_OFS_CONTROL, c & 8'hfe);
    wr(`TMC_OFS_COUNT_HIGH, 8'h00);
    wr(`TMC_OFS_COUNT_LOW, 8'h00);
    x0 = ext_n;
    o0 = osc_n;
    wr(`TMC_OFS_CONTROL, c);
    repeat (240) @(posedge clk_sys_i);
    wr(`TMC_OFS_CONTROL, c & 8'hfe);
    e = c[3] ? osc_n - o0 : ext_n - x0;
    rd(`TMC_OFS_COUNT_LOW, 32'h0, 32'h0);
    v = int'(d[7:0]);
  endtask

  function automatic logic [31:0] near(input int a, input int b);
    return {31'h0, (a - b <= 2) && (b - a <= 2)};
  endfunction

  task automatic pulse(input bit w);
    @(posedge clk_sys_i);
    if (w) wake <= 1'b1;
    else sleep <= 1'b1;
    @(posedge clk_sys_i);
    wake <= 1'b0;
    sleep <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(`TMC_OFS_CONTROL, 32'h0, '1);
    rd(`TMC_OFS_IRQ_FLAGS, 32'h0, '1);
    rd(`TMC_OFS_OSC_CONTROL, 32'h0, '1);
    wr(`TMC_OFS_CONTROL, 8'hf4);
    rd(`TMC_OFS_CONTROL, 32'hb4, '1);
    wr(6'h3c, 8'h55);
    rd(6'h3c, 32'h0, '1);
    wr(`TMC_OFS_CONTROL, 8'h00);
    // Direct byte access with random data
    repeat (4) begin
      r = $random(seed);
      wr(`TMC_OFS_COUNT_HIGH, r[7:0]);
      rd(`TMC_OFS_COUNT_HIGH, {24'h0, r[7:0]}, '1);
      wr(`TMC_OFS_COUNT_LOW, r[15:8]);
      rd(`TMC_OFS_COUNT_LOW, {24'h0, r[15:8]}, '1);
    end
    // Paired access through the high buffer
    wr(`TMC_OFS_CONTROL, 8'h80);
    wr(`TMC_OFS_COUNT_HIGH, 8'h12);
    wr(`TMC_OFS_COUNT_LOW, 8'h34);
    rd(`TMC_OFS_COUNT_LOW, 32'h34, '1);
    rd(`TMC_OFS_COUNT_HIGH, 32'h12, '1);
    wr(`TMC_OFS_CONTROL, 8'h00);
    rd(`TMC_OFS_COUNT_HIGH, 32'h12, '1);
    // Wrap near the top, flag then interrupt gating
    wr(`TMC_OFS_COUNT_HIGH, 8'hff);
    wr(`TMC_OFS_COUNT_LOW, 8'hfe);
    wr(`TMC_OFS_CONTROL, 8'h01);
    repeat (20) @(posedge clk_sys_i);
    wr(`TMC_OFS_CONTROL, 8'h00);
    rd(`TMC_OFS_IRQ_FLAGS, 32'h1, '1);
    rd(`TMC_OFS_COUNT_HIGH, 32'h0, '1);
    chk({31'h0, irq}, 32'h0);
    wr(`TMC_OFS_IRQ_ENABLES, 8'h01);
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, irq}, 32'h1);
    wr(`TMC_OFS_IRQ_FLAGS, 8'h00);
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, irq}, 32'h0);
    // Compare trigger as period, no overflow
    wr(`TMC_OFS_CMP_LOW, 8'h10);
    wr(`TMC_OFS_CMP_HIGH, 8'h00);
    wr(`TMC_OFS_CMP_MODE, 8'h0b);
    run_cnt(8'h01);
    chk({31'h0, v <= 16}, 32'h1);
    rd(`TMC_OFS_IRQ_FLAGS, 32'h0, '1);
    rd(`TMC_OFS_COUNT_HIGH, 32'h0, '1);
    // Asynchronous counting passes the compare value
    wr(`TMC_OFS_CMP_LOW, 8'h04);
    run_cnt(8'h07);
    chk(near(v, e), 32'h1);
    wr(`TMC_OFS_CMP_MODE, 8'h00);
    // Every prescale code on the internal clock
    for (int k = 0; k < 4; k++) begin
      run_cnt({2'b00, 2'(k), 4'h1});
      chk(near(v, 120 >> k), 32'h1);
    end
    run_cnt(8'h03);
    chk(near(v, e), 32'h1);
    run_cnt(8'h0b);
    chk(near(v, e), 32'h1);
    // Power modes on the oscillator clock
    wr(`TMC_OFS_OSC_CONTROL, 8'h01);
    repeat (2) @(posedge clk_sys_i);
    chk({29'h0, pmode, status}, 32'h3);
    rd(`TMC_OFS_CONTROL, 32'h4a, '1);
    pulse(1'b0);
    chk({30'h0, pmode}, 32'h3);
    pulse(1'b1);
    chk({30'h0, pmode}, 32'h1);
    wr(`TMC_OFS_OSC_CONTROL, 8'h81);
    pulse(1'b0);
    chk({30'h0, pmode}, 32'h2);
    pulse(1'b1);
    wr(`TMC_OFS_OSC_CONTROL, 8'h41);
    @(posedge clk_sys_i);
    fail <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    chk({29'h0, pmode, status}, 32'h0);
    rd(`TMC_OFS_OSC_CONTROL, 32'h40, '1);
    fail <= 1'b0;
    // clock-style use: oscillator, async counting, interrupt on
    wr(`TMC_OFS_IRQ_ENABLES, 8'h01);
    wr(`TMC_OFS_CONTROL, 8'h0f);
    // preload touches the high byte only
    wr(`TMC_OFS_COUNT_HIGH, 8'hff);
    n_wait = 0;
    while (irq !== 1'b1 && n_wait < 8000) begin
      @(posedge clk_sys_i);
      n_wait++;
    end
    if (n_wait == 8000) begin
      num_errors++;
      $display("wrong value at %0t: overflow never came", $time);
      final_report();
    end
    // poll the low byte for a fresh step, then update
    rd(`TMC_OFS_COUNT_LOW, 32'h0, 32'h0);
    r = d;
    n_wait = 0;
    while (d == r && n_wait < 64) begin
      rd(`TMC_OFS_COUNT_LOW, 32'h0, 32'h0);
      n_wait++;
    end
    chk({31'h0, d != r}, 32'h1);
    // set the top bit of the high byte, low byte untouched
    rd(`TMC_OFS_COUNT_HIGH, 32'h0, '1);
    wr(`TMC_OFS_COUNT_HIGH, d[7:0] | 8'h80);
    wr(`TMC_OFS_IRQ_FLAGS, 8'h00);
    rd(`TMC_OFS_COUNT_HIGH, 32'h80, '1);
    rd(`TMC_OFS_IRQ_FLAGS, 32'h0, '1);
    final_report();
  end
endmodule
